// *** hdl/cpw_top.sv ***
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "cpw_cfg.svh"
module cpw_top (
    input  wire logic                CLK,
    input  wire logic                SRST,
    input  wire cpw_pkg::cpw_addr_t  ADDR,
    input  wire cpw_pkg::cpw_byte_t  WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output cpw_pkg::cpw_byte_t       RDATA,
    output logic                     PIN4_OUT,
    output logic                     PIN4_OE_N,
    output logic                     PIN5_OUT,
    output logic                     PIN5_OE_N,
    output logic                     TB_A_POST,
    output logic                     TB_B_POST
);
    import cpw_pkg::*;

    cpw_byte_t period_limit_a;
    cpw_byte_t period_limit_b;
    cpw_byte_t time_base_ctrl_a;
    cpw_byte_t time_base_ctrl_b;
    cpw_byte_t duty_write_reg4;
    cpw_byte_t duty_write_reg5;
    cpw_byte_t unit_control_reg4;
    cpw_byte_t unit_control_reg5;
    cpw_byte_t open_drain_ctrl;
    cpw_byte_t shared_address_ctrl;
    cpw_byte_t unit_timer_sel;
    cpw_byte_t port_direction_reg;
    cpw_byte_t duty_shadow_reg4;
    cpw_byte_t duty_shadow_reg5;
    cpw_byte_t next_rdata;
    logic [1:0] frac4;
    logic [1:0] frac5;
    logic       out4;
    logic       out5;
    logic       wr_cnt_a;
    logic       wr_cnt_b;
    logic       shared_sel;
    logic       act4;
    logic       match4;

    cpw_tb_if tb_a ();
    cpw_tb_if tb_b ();
    cpw_tb_if tb_u4 ();
    cpw_tb_if tb_u5 ();

    assign shared_sel = shared_address_ctrl[`CPW_SHARED_SEL];
    assign wr_cnt_a   = WR && (ADDR == `CPW_A_CNT);
    assign wr_cnt_b   = WR && (ADDR == `CPW_B_CNT);

    // Two selectable time bases
    cpw_timebase u_tb_a (
        .clk          (CLK),
        .srst         (SRST),
        .period_limit (period_limit_a),
        .ctrl         (time_base_ctrl_a),
        .cnt_wr       (wr_cnt_a),
        .cnt_wdata    (WDATA),
        .post_evt     (TB_A_POST),
        .tb           (tb_a.src)
    );

    cpw_timebase u_tb_b (
        .clk          (CLK),
        .srst         (SRST),
        .period_limit (period_limit_b),
        .ctrl         (time_base_ctrl_b),
        .cnt_wr       (wr_cnt_b),
        .cnt_wdata    (WDATA),
        .post_evt     (TB_B_POST),
        .tb           (tb_b.src)
    );

    // Route the selected time base to each unit
    assign tb_u4.count = unit_timer_sel[0] ? tb_b.count : tb_a.count;
    assign tb_u4.frac  = unit_timer_sel[0] ? tb_b.frac  : tb_a.frac;
    assign tb_u4.start = unit_timer_sel[0] ? tb_b.start : tb_a.start;
    assign tb_u4.on    = unit_timer_sel[0] ? tb_b.on    : tb_a.on;
    assign tb_u5.count = unit_timer_sel[1] ? tb_b.count : tb_a.count;
    assign tb_u5.frac  = unit_timer_sel[1] ? tb_b.frac  : tb_a.frac;
    assign tb_u5.start = unit_timer_sel[1] ? tb_b.start : tb_a.start;
    assign tb_u5.on    = unit_timer_sel[1] ? tb_b.on    : tb_a.on;

    // Two modulation units
    cpw_channel u_ch4 (
        .clk          (CLK),
        .srst         (SRST),
        .ctl          (unit_control_reg4),
        .duty_low     (duty_write_reg4),
        .shadow_wr    (WR && ADDR == `CPW_DUTYH4),
        .shadow_wdata (WDATA),
        .duty_shadow  (duty_shadow_reg4),
        .duty_frac    (frac4),
        .pwm_out      (out4),
        .tb           (tb_u4.snk)
    );

    cpw_channel u_ch5 (
        .clk          (CLK),
        .srst         (SRST),
        .ctl          (unit_control_reg5),
        .duty_low     (duty_write_reg5),
        .shadow_wr    (WR && ADDR == `CPW_DUTYH5),
        .shadow_wdata (WDATA),
        .duty_shadow  (duty_shadow_reg5),
        .duty_frac    (frac5),
        .pwm_out      (out5),
        .tb           (tb_u5.snk)
    );

    // Time base period and control registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            period_limit_a   <= `CPW_ZERO8;
            period_limit_b   <= `CPW_ZERO8;
            time_base_ctrl_a <= `CPW_ZERO8;
            time_base_ctrl_b <= `CPW_ZERO8;
        end else if (WR) begin
            if (ADDR == `CPW_A_PER && !shared_sel) begin
                period_limit_a <= WDATA;
            end
            if (ADDR == `CPW_B_PER) begin
                period_limit_b <= WDATA;
            end
            if (ADDR == `CPW_A_CTL) begin
                time_base_ctrl_a <= WDATA & `CPW_TCTL_MASK;
            end
            if (ADDR == `CPW_B_CTL) begin
                time_base_ctrl_b <= WDATA & `CPW_TCTL_MASK;
            end
        end
    end

    // Duty bytes and unit control registers, writable at any time
    always_ff @(posedge CLK) begin
        if (SRST) begin
            duty_write_reg4   <= `CPW_ZERO8;
            duty_write_reg5   <= `CPW_ZERO8;
            unit_control_reg4 <= `CPW_ZERO8;
            unit_control_reg5 <= `CPW_ZERO8;
        end else if (WR) begin
            if (ADDR == `CPW_DUTYL4) begin
                duty_write_reg4 <= WDATA;
            end
            if (ADDR == `CPW_DUTYL5) begin
                duty_write_reg5 <= WDATA;
            end
            if (ADDR == `CPW_UCTL4) begin
                unit_control_reg4 <= WDATA & `CPW_UCTL_MASK;
            end
            if (ADDR == `CPW_UCTL5) begin
                unit_control_reg5 <= WDATA & `CPW_UCTL_MASK;
            end
        end
    end

    // Open-drain select, shared-address select, timer routing and direction
    always_ff @(posedge CLK) begin
        if (SRST) begin
            open_drain_ctrl     <= `CPW_ZERO8;
            shared_address_ctrl <= `CPW_ZERO8;
            unit_timer_sel      <= `CPW_ZERO8;
            port_direction_reg  <= `CPW_PDIR_RST;
        end else if (WR) begin
            if (ADDR == `CPW_A_PER && shared_sel) begin
                open_drain_ctrl <= WDATA & `CPW_OD_MASK;
            end
            if (ADDR == `CPW_SHARED) begin
                shared_address_ctrl <= WDATA & `CPW_SH_MASK;
            end
            if (ADDR == `CPW_TSEL) begin
                unit_timer_sel <= WDATA & `CPW_TSEL_MASK;
            end
            if (ADDR == `CPW_PDIR) begin
                port_direction_reg <= WDATA & `CPW_PDIR_MASK;
            end
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        unique case (ADDR)
            `CPW_A_CNT:  next_rdata = tb_a.count;
            `CPW_A_PER:  next_rdata = shared_sel ? open_drain_ctrl : period_limit_a;
            `CPW_A_CTL:  next_rdata = time_base_ctrl_a;
            `CPW_B_CNT:  next_rdata = tb_b.count;
            `CPW_B_PER:  next_rdata = period_limit_b;
            `CPW_B_CTL:  next_rdata = time_base_ctrl_b;
            `CPW_DUTYL4: next_rdata = duty_write_reg4;
            `CPW_DUTYH4: next_rdata = duty_shadow_reg4;
            `CPW_DUTYL5: next_rdata = duty_write_reg5;
            `CPW_DUTYH5: next_rdata = duty_shadow_reg5;
            `CPW_UCTL4:  next_rdata = unit_control_reg4;
            `CPW_UCTL5:  next_rdata = unit_control_reg5;
            `CPW_SHARED: next_rdata = shared_address_ctrl;
            `CPW_TSEL:   next_rdata = unit_timer_sel;
            `CPW_PDIR:   next_rdata = port_direction_reg;
            default:     next_rdata = `CPW_ZERO8;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (SRST) begin
            RDATA <= `CPW_ZERO8;
        end else begin
            RDATA <= RD ? next_rdata : `CPW_ZERO8;
        end
    end

    // Pin drivers; open-drain drives only the low level
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PIN4_OUT  <= 1'b0;
            PIN4_OE_N <= 1'b1;
            PIN5_OUT  <= 1'b0;
            PIN5_OE_N <= 1'b1;
        end else begin
            PIN4_OUT  <= out4 && !open_drain_ctrl[`CPW_OD4];
            PIN4_OE_N <= port_direction_reg[0] || (out4 && open_drain_ctrl[`CPW_OD4]);
            PIN5_OUT  <= out5 && !open_drain_ctrl[`CPW_OD5];
            PIN5_OE_N <= port_direction_reg[1] || (out5 && open_drain_ctrl[`CPW_OD5]);
        end
    end

    // Checks on time base A, unit 4 and the register port
    assign act4   = cpw_is_pwm(unit_control_reg4) && tb_u4.on;
    assign match4 = ({duty_shadow_reg4, frac4} == {tb_u4.count, tb_u4.frac});

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    sequence s_start4;
        act4 && tb_u4.start;
    endsequence

    sequence s_ctl4_clear;
        WR && ADDR == `CPW_UCTL4 && WDATA == `CPW_ZERO8;
    endsequence

    property p_period_wrap;
        tb_a.start && !wr_cnt_a |=> tb_a.count == `CPW_ZERO8;
    endproperty
    a_period_wrap: assert property (p_period_wrap)
        else $error("timer did not wrap after period match");

    property p_start_high;
        s_start4 ##0 (cpw_duty10(duty_write_reg4, unit_control_reg4) != `CPW_ZERO10)
            |=> out4 ##1 PIN4_OUT || open_drain_ctrl[`CPW_OD4];
    endproperty
    a_start_high: assert property (p_start_high)
        else $error("output not set at period start");

    property p_zero_low;
        s_start4 ##0 (cpw_duty10(duty_write_reg4, unit_control_reg4) == `CPW_ZERO10)
            |=> !out4;
    endproperty
    a_zero_low: assert property (p_zero_low)
        else $error("zero duty drove output high");

    property p_latch;
        s_start4 |=> duty_shadow_reg4 == $past(duty_write_reg4)
            && frac4 == $past(unit_control_reg4[`CPW_DCB_HI:`CPW_DCB_LO]);
    endproperty
    a_latch: assert property (p_latch)
        else $error("duty not moved into shadow at period start");

    property p_match_clear;
        act4 && !tb_u4.start && match4 |=> !out4 && !PIN4_OUT;
    endproperty
    a_match_clear: assert property (p_match_clear)
        else $error("output not cleared on duty match");

    property p_hold_high;
        act4 && out4 && !tb_u4.start |=> out4 || match4 || !act4;
    endproperty
    a_hold_high: assert property (p_hold_high)
        else $error("output cleared without a duty match");

    property p_disabled;
        !tb_u4.on |=> !out4;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("output high while timer disabled");

    property p_shadow_ro;
        WR && ADDR == `CPW_DUTYH4 && cpw_is_pwm(unit_control_reg4) && !tb_u4.start
            |=> $stable(duty_shadow_reg4);
    endproperty
    a_shadow_ro: assert property (p_shadow_ro)
        else $error("shadow duty changed by a write in modulation mode");

    property p_ctl_clear;
        s_ctl4_clear |-> ##2 (!out4 [*3]);
    endproperty
    a_ctl_clear: assert property (p_ctl_clear)
        else $error("output not forced low after control clear");

    property p_alias;
        WR && ADDR == `CPW_A_PER && shared_sel |=> $stable(period_limit_a)
            ##1 RD && ADDR == `CPW_A_PER && shared_sel |=> RDATA == open_drain_ctrl;
    endproperty
    a_alias: assert property (p_alias)
        else $error("shared address reached the period register");

    property p_post;
        TB_A_POST |-> $past(tb_a.start);
    endproperty
    a_post: assert property (p_post)
        else $error("postscaled event without a period match");
endmodule
`default_nettype wire

// *** include/cpw_cfg.svh ***
`ifndef CPW_CFG_SVH
`define CPW_CFG_SVH
// Overview of operation
// - Period is (period limit + 1) x 4 system clocks x prescale factor.
// - Timer equal to period limit is cleared on the next increment.
// - Each period start drives the pin high unless duty is zero.
// - Each period start copies the written duty into the shadow buffer.
// - Timer postscaler never alters the modulation period.
// - Duty is 10 bits: duty write byte on top, control bits 5:4 below.
// - Pin clears when shadow duty equals timer extended by two phase bits.
// - Duty writes are accepted anytime and take effect next period.
// - In modulation mode the shadow duty reads back and ignores writes.
// - Shadow byte plus a private 2-bit latch double-buffer the duty.
// - Duty longer than period keeps the pin high all period.
// - Timer prescaler divides by one, four or sixteen.
// - Open-drain select shares an address, visible only when select bit is one.
// - Clearing the unit control register forces the output latch low.

// Register offsets on the plain register port
`define CPW_A_CNT      4'h0
`define CPW_A_PER      4'h1
`define CPW_A_CTL      4'h2
`define CPW_B_CNT      4'h3
`define CPW_B_PER      4'h4
`define CPW_B_CTL      4'h5
`define CPW_DUTYL4     4'h6
`define CPW_DUTYH4     4'h7
`define CPW_DUTYL5     4'h8
`define CPW_DUTYH5     4'h9
`define CPW_UCTL4      4'hA
`define CPW_UCTL5      4'hB
`define CPW_SHARED     4'hC
`define CPW_TSEL       4'hD
`define CPW_PDIR       4'hE
// Field positions
`define CPW_TB_ON      2
`define CPW_CKPS_HI    1
`define CPW_CKPS_LO    0
`define CPW_OPS_HI     6
`define CPW_OPS_LO     3
`define CPW_DCB_HI     5
`define CPW_DCB_LO     4
`define CPW_MODE_HI    3
`define CPW_MODE_LO    2
`define CPW_SHARED_SEL 4
`define CPW_OD4        3
`define CPW_OD5        4
// Write masks, reset values and codes
`define CPW_TCTL_MASK  8'h7F
`define CPW_UCTL_MASK  8'h3F
`define CPW_OD_MASK    8'h1F
`define CPW_SH_MASK    8'h10
`define CPW_TSEL_MASK  8'h03
`define CPW_PDIR_MASK  8'h03
`define CPW_PDIR_RST   8'h03
`define CPW_ZERO8      8'h00
`define CPW_ZERO10     10'h000
`define CPW_PWM_CODE   2'h3
`define CPW_Q_LAST     2'h3
`define CPW_PRE1_LAST  4'h0
`define CPW_PRE4_LAST  4'h3
`define CPW_PRE16_LAST 4'hF
`endif

// *** include/cpw_pkg.sv ***
`include "cpw_cfg.svh"
package cpw_pkg;
    typedef enum logic [2:0] {
        CPW_IDLE = 3'b001,
        CPW_HIGH = 3'b010,
        CPW_LOW  = 3'b100
    } cpw_out_state_t;
    typedef logic [3:0] cpw_addr_t;
    typedef logic [7:0] cpw_byte_t;

    // Joins the duty byte with the two fraction bits of a unit control value
    function automatic logic [9:0] cpw_duty10(input cpw_byte_t low, input cpw_byte_t ctl);
        cpw_duty10 = {low, ctl[`CPW_DCB_HI:`CPW_DCB_LO]};
    endfunction

    // True when a unit control value selects modulation mode
    function automatic logic cpw_is_pwm(input cpw_byte_t ctl);
        cpw_is_pwm = (ctl[`CPW_MODE_HI:`CPW_MODE_LO] == `CPW_PWM_CODE);
    endfunction
endpackage

// *** include/cpw_tb_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface cpw_tb_if;
    logic [7:0] count;
    logic [1:0] frac;
    logic       start;
    logic       on;
    modport src (output count, frac, start, on);
    modport snk (input count, frac, start, on);
endinterface
`default_nettype wire

// *** hdl/cpw_timebase.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cpw_cfg.svh"
module cpw_timebase (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire cpw_pkg::cpw_byte_t  period_limit,
    input  wire cpw_pkg::cpw_byte_t  ctrl,
    input  wire logic                cnt_wr,
    input  wire cpw_pkg::cpw_byte_t  cnt_wdata,
    output logic                     post_evt,
    cpw_tb_if.src                    tb
);
    import cpw_pkg::*;
    logic [1:0] q_phase;
    logic [3:0] pre_cnt;
    logic [3:0] pre_last;
    logic [3:0] post_cnt;
    logic [7:0] count;
    logic       tick;

    // Prescale limit and fraction bits from the prescale field
    always_comb begin
        unique case (ctrl[`CPW_CKPS_HI:`CPW_CKPS_LO])
            2'h0: begin
                pre_last = `CPW_PRE1_LAST;
                tb.frac  = q_phase;
            end
            2'h1: begin
                pre_last = `CPW_PRE4_LAST;
                tb.frac  = pre_cnt[1:0];
            end
            2'h2, 2'h3: begin
                pre_last = `CPW_PRE16_LAST;
                tb.frac  = pre_cnt[3:2];
            end
        endcase
    end

    assign tb.on    = ctrl[`CPW_TB_ON];
    assign tb.count = count;
    assign tick     = tb.on && (q_phase == `CPW_Q_LAST) && (pre_cnt == pre_last);
    assign tb.start = tick && (count == period_limit);

    // Quarter-cycle phase of the instruction cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            q_phase <= 2'h0;
        end else begin
            q_phase <= q_phase + 2'h1;
        end
    end

    // Prescaler, cleared by a counter write
    always_ff @(posedge clk) begin
        if (srst || cnt_wr) begin
            pre_cnt <= 4'h0;
        end else if (tb.on && q_phase == `CPW_Q_LAST) begin
            pre_cnt <= (pre_cnt == pre_last) ? 4'h0 : pre_cnt + 4'h1;
        end
    end

    // Timer counter
    always_ff @(posedge clk) begin
        if (srst) begin
            count <= `CPW_ZERO8;
        end else if (cnt_wr) begin
            count <= cnt_wdata;
        end else if (tick) begin
            count <= tb.start ? `CPW_ZERO8 : count + 8'h01;
        end
    end

    // Postscaler only paces its own event output
    always_ff @(posedge clk) begin
        if (srst) begin
            post_cnt <= 4'h0;
            post_evt <= 1'b0;
        end else begin
            post_evt <= 1'b0;
            if (tb.start) begin
                if (post_cnt == ctrl[`CPW_OPS_HI:`CPW_OPS_LO]) begin
                    post_cnt <= 4'h0;
                    post_evt <= 1'b1;
                end else begin
                    post_cnt <= post_cnt + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** hdl/cpw_channel.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cpw_cfg.svh"
module cpw_channel (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire cpw_pkg::cpw_byte_t  ctl,
    input  wire cpw_pkg::cpw_byte_t  duty_low,
    input  wire logic                shadow_wr,
    input  wire cpw_pkg::cpw_byte_t  shadow_wdata,
    output cpw_pkg::cpw_byte_t       duty_shadow,
    output logic [1:0]               duty_frac,
    output logic                     pwm_out,
    cpw_tb_if.snk                    tb
);
    import cpw_pkg::*;
    cpw_out_state_t state;
    cpw_out_state_t next_state;
    logic           active;
    logic           hit;

    assign active = cpw_is_pwm(ctl) && tb.on;
    assign hit    = ({duty_shadow, duty_frac} == {tb.count, tb.frac});

    // Output drops in the very cycle the timer reaches the duty, so high time is exactly duty
    assign pwm_out = (state == CPW_HIGH) && !hit;

    // Shadow duty byte and private fraction latch
    always_ff @(posedge clk) begin
        if (srst) begin
            duty_shadow <= `CPW_ZERO8;
            duty_frac   <= 2'h0;
        end else if (active && tb.start) begin
            duty_shadow <= duty_low;
            duty_frac   <= ctl[`CPW_DCB_HI:`CPW_DCB_LO];
        end else if (shadow_wr && !cpw_is_pwm(ctl)) begin
            duty_shadow <= shadow_wdata;
        end
    end

    // Output sequencing
    always_comb begin
        next_state = state;
        if (!active) begin
            next_state = CPW_IDLE;
        end else if (tb.start) begin
            next_state = (cpw_duty10(duty_low, ctl) == `CPW_ZERO10) ? CPW_LOW : CPW_HIGH;
        end else if (state == CPW_HIGH && hit) begin
            next_state = CPW_LOW;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= CPW_IDLE;
        end else begin
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

// *** tb/cpw_load.sv ***
`timescale 1ns/1ns
`default_nettype none
// External load on one output pin, with a pull-up resistor
module cpw_load (
    input  wire logic drive,
    input  wire logic oe_n,
    output logic      level
);
    // A released pin is pulled up, never left at its last value
    assign level = oe_n ? 1'b1 : drive;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cpw_cfg.svh"
module tb_top;
    import cpw_pkg::*;
    logic       clk;
    logic       srst;
    cpw_addr_t  addr;
    cpw_byte_t  wdata;
    logic       wr;
    logic       rd;
    cpw_byte_t  rdata;
    logic [1:0] pout;
    logic [1:0] poe_n;
    logic [1:0] lvl;
    int         failures = 0;
    int         comparisons = 0;
    int         cycles = 0;
    cpw_addr_t  a_cnt[2] = '{4'h0, 4'h3};
    cpw_addr_t  a_per[2] = '{4'h1, 4'h4};
    cpw_addr_t  a_ctl[2] = '{4'h2, 4'h5};
    cpw_addr_t  a_dl[2] = '{4'h6, 4'h8};
    cpw_addr_t  a_uc[2] = '{4'hA, 4'hB};

    cpw_top u_dut (
        .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .PIN4_OUT(pout[0]), .PIN4_OE_N(poe_n[0]),
        .PIN5_OUT(pout[1]), .PIN5_OE_N(poe_n[1]), .TB_A_POST(), .TB_B_POST()
    );
    cpw_load u_load4 (.drive(pout[0]), .oe_n(poe_n[0]), .level(lvl[0]));
    cpw_load u_load5 (.drive(pout[1]), .oe_n(poe_n[1]), .level(lvl[1]));

    // Clock at 125 MHz
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Cuts a hung run short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            failures = failures + 1;
            report_and_stop();
        end
    end

    // Prints the counts and the verdict, then ends the run
    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Compares a register or pin value
    task automatic chk_reg(input string n, input cpw_byte_t e, input cpw_byte_t g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // Compares a measured cycle count
    task automatic chk_time(input string n, input int e, input int g);
        comparisons++;
        if (g != e) begin
            failures++;
            $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
        end
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input cpw_addr_t a, input cpw_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic rd_chk(input cpw_addr_t a, input cpw_byte_t e, input string n);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_reg(n, e, rdata);
    endtask

    // High cycles over a window and spacing of the first two rises
    task automatic sample(input int u, input int w, output int hi, output int sp);
        int   e1;
        logic prev;
        hi = 0;
        sp = 0;
        e1 = -1;
        @(posedge clk);
        #1 prev = lvl[u];
        for (int t = 0; t < w; t++) begin
            @(posedge clk);
            #1;
            hi += int'(lvl[u]);
            if (lvl[u] && !prev && e1 >= 0 && sp == 0)
                sp = t - e1;
            if (lvl[u] && !prev && e1 < 0)
                e1 = t;
            prev = lvl[u];
        end
    endtask

    function automatic int pre_of(input int c);
        return (c == 0) ? 1 : (c == 1) ? 4 : 16;
    endfunction

    // Expected high cycles over two whole periods
    function automatic int exp_hi(input int d, input int p, input int pre);
        if (d == 0)
            return 0;
        if (d >= (p + 1) * 4)
            return 8 * (p + 1) * pre;
        return 2 * d * pre;
    endfunction

    // Programs one unit and measures its output
    task automatic run_pwm(input int u, input int p, input int pc, input int d);
        int per;
        int hi;
        int sp;
        per = (p + 1) * 4 * pre_of(pc);
        wr_reg(a_uc[u], 8'h00);
        repeat (3) @(posedge clk);
        #1 chk_reg("pin cleared", 8'h00, {7'h00, pout[u]});
        wr_reg(a_ctl[u], 8'h00);
        wr_reg(a_cnt[u], 8'h00);
        wr_reg(a_per[u], 8'(p));
        wr_reg(a_dl[u], 8'(d >> 2));
        wr_reg(a_uc[u], {2'b00, 2'(d), 4'h0});
        wr_reg(`CPW_PDIR, 8'h00);
        wr_reg(a_ctl[u], {1'b0, 4'($urandom_range(15)), 1'b1, 2'(pc)});
        wr_reg(a_uc[u], {2'b00, 2'(d), 4'hC});
        repeat (2 * per + 8) @(posedge clk);
        sample(u, 2 * per, hi, sp);
        chk_time("high time", exp_hi(d, p, pre_of(pc)), hi);
        if (hi != 0 && hi != 2 * per)
            chk_time("period", per, sp);
    endtask

    // Main sequence
    initial begin
        int p;
        int d;
        int hi;
        int sp;
        srst = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        void'($urandom(62908));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rd_chk(`CPW_PDIR, `CPW_PDIR_RST, "direction reset");
        rd_chk(`CPW_UCTL4, 8'h00, "unit control reset");
        wr_reg(4'hF, 8'hA5);
        rd_chk(4'hF, 8'h00, "unmapped");
        $display("test reset done");
        wr_reg(`CPW_TSEL, 8'h02);
        for (int i = 0; i < 5; i++) begin
            for (int u = 0; u < 2; u++) begin
                p = $urandom_range(15);
                d = $urandom_range((p + 1) * 4 - 1, 1);
                if (i == 0)
                    d = 0;
                if (i == 1)
                    d = (p + 1) * 4 + $urandom_range(9);
                if (i == 2)
                    d = (p + 1) * 4 - 1;
                run_pwm(u, p, $urandom_range(3), d);
            end
        end
        $display("test modulation done");
        run_pwm(0, 15, 0, 20);
        @(posedge lvl[0]);
        wr_reg(`CPW_DUTYL4, 8'h0A);
        rd_chk(`CPW_DUTYH4, 8'h05, "shadow kept");
        repeat (70) @(posedge clk);
        rd_chk(`CPW_DUTYH4, 8'h0A, "shadow loaded");
        wr_reg(`CPW_DUTYH4, 8'h5A);
        rd_chk(`CPW_DUTYH4, 8'h0A, "shadow locked");
        sample(0, 128, hi, sp);
        chk_time("new high time", 80, hi);
        wr_reg(`CPW_A_CTL, 8'h00);
        repeat (4) @(posedge clk);
        sample(0, 64, hi, sp);
        chk_time("timer off", 0, hi);
        $display("test shadow done");
        wr_reg(`CPW_SHARED, 8'h10);
        wr_reg(`CPW_A_PER, 8'h08);
        rd_chk(`CPW_A_PER, 8'h08, "open drain select");
        wr_reg(`CPW_SHARED, 8'h00);
        rd_chk(`CPW_A_PER, 8'h0F, "period alias");
        $display("test shared address done");
        report_and_stop();
    end
endmodule
`default_nettype wire
